// ==== src/bert.sv ====
/*
  Bit error rate tester: AHB-Lite register slave, transmit pattern mux and
  receive checker with synchronizer and counters.
  Assumes line-side bit strobes and active-slot flags are synchronous to hclk.
*/
// Functional notes
// (R1) pattern codes: four prbs, repeat, alternating
// (R2) qrss 2^20-1, one forced after fourteen zeros
// (R3) repetitive pattern of one to 32 bits
// (R4) two 16-bit words alternate every 1-256
// (R5) 32-bit bit counter, 24-bit error counter
// (R6) events: bit error, sync change, overflow
// (R7) per-source enables in bits 13-15
// (R8) host programs mux before tester runs
// (R9) rx select: off, slots, whole frame, illegal
// (R10) tx select 01 replaces active slots only
// (R11) tx select 10 replaces all bits
// (R12) realign rising edge restarts synchronizer
// (R13) host toggles realign low then high
// (R14) latch rising edge copies and clears counts
// (R15) rx invert flips incoming data
// (R16) tx invert flips generated data
// (R17) length code plus seventeen gives length
// (R18) length code ignored for pseudorandom patterns
// (R19) short repeats use multiples up to 32
// (R20) both counts latched in one cycle
`timescale 1ns/1ps
module bert (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tx_bit_en,
  input wire logic tx_active_slot,
  input wire logic tx_data_in,
  output logic tx_data_out,
  input wire logic rx_bit_en,
  input wire logic rx_active_slot,
  input wire logic rx_data_in,
  output logic irq
);
  typedef enum logic {HUNT, LOCKED} sync_state_t;

  logic [15:0] mux_ctrl_r;
  logic [15:0] ctrl0_r;
  logic [31:0] pattern_r;
  logic [7:0] awc_r;
  logic [1:0] prev_edge_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic tx_out_r;
  logic tx_load_r;
  sync_state_t state_r;
  logic [5:0] match_r;
  logic [5:0] win_r;
  logic [2:0] errs_r;
  logic [31:0] bit_cnt_r;
  logic [23:0] err_cnt_r;
  logic [31:0] bit_latch_r;
  logic [23:0] err_latch_r;
  logic [2:0] sticky_r;

  // bus decode
  wire addr_ok = hsel && hready && htrans[1] && hsize == 3'h2;
  wire rd_req = addr_ok && !hwrite;
  wire wr_mux = wr_pend_r && wr_addr_r == bert_pkg::OFF_MUX_CTRL;
  wire wr_ctrl0 = wr_pend_r && wr_addr_r == bert_pkg::OFF_CTRL0;
  wire wr_pat = wr_pend_r && wr_addr_r == bert_pkg::OFF_PATTERN;
  wire wr_awc = wr_pend_r && wr_addr_r == bert_pkg::OFF_AWC;
  wire wr_stat = wr_pend_r && wr_addr_r == bert_pkg::OFF_STATUS;

  // control fields
  wire [1:0] rx_sel = mux_ctrl_r[bert_pkg::RX_SEL_LSB +: 2];
  wire [1:0] tx_sel = mux_ctrl_r[bert_pkg::TX_SEL_LSB +: 2];
  wire [2:0] pat_sel = ctrl0_r[bert_pkg::PATTERN_SEL_LSB +: 3];
  wire [3:0] len_code = ctrl0_r[bert_pkg::REPEAT_LEN_LSB +: 4];
  wire pat_legal = pat_sel <= bert_pkg::PAT_ALT_WORD; // R1
  wire rx_inv = ctrl0_r[bert_pkg::RX_INVERT_BIT];
  wire tx_inv = ctrl0_r[bert_pkg::TX_INVERT_BIT];
  wire [2:0] irq_en = {ctrl0_r[bert_pkg::SYNC_CHANGE_IE_BIT],
                       ctrl0_r[bert_pkg::BIT_ERROR_IE_BIT],
                       ctrl0_r[bert_pkg::OVERFLOW_IE_BIT]};
  wire realign_rise = ctrl0_r[bert_pkg::FORCE_REALIGN_BIT] && !prev_edge_r[0]; // R12
  wire latch_rise = ctrl0_r[bert_pkg::LATCH_COUNTS_BIT] && !prev_edge_r[1]; // R14

  // transmit side: 00 passes, 01 active slots, 10 every bit, 11 treated as off
  wire tx_take = pat_legal && ((tx_sel == bert_pkg::SEL_ACTIVE_SLOTS && tx_active_slot) // R10
                 || tx_sel == bert_pkg::SEL_WHOLE_FRAME); // R11
  wire tx_step = tx_bit_en && tx_take;
  wire tx_load = wr_ctrl0 || wr_pat || wr_awc;
  wire tx_gen;

  // receive side: 00 off, 01 active slots, 10 whole frame, 11 treated as off
  wire rx_take = pat_legal && ((rx_sel == bert_pkg::SEL_ACTIVE_SLOTS && rx_active_slot)
                 || rx_sel == bert_pkg::SEL_WHOLE_FRAME); // R9
  wire rx_step = rx_bit_en && rx_take;
  wire rx_bit = rx_data_in ^ rx_inv; // R15
  wire rx_pred;
  wire rx_aligned;
  wire rx_load = realign_rise || wr_ctrl0 || wr_pat || wr_awc; // R12
  wire judged = rx_step && rx_aligned;
  wire mismatch = rx_bit != rx_pred;
  wire locked = state_r == LOCKED;
  wire bit_error = judged && locked && mismatch;

  // synchronizer transitions
  wire gain_sync = !locked && judged && !mismatch && match_r == bert_pkg::SYNC_MATCHES - 6'h1;
  wire lose_sync = bit_error && errs_r == bert_pkg::LOSS_ERRORS - 3'h1;
  // a reload drops lock as well, so it counts as a change
  wire sync_change = locked ? (lose_sync || rx_load) : (gain_sync && !rx_load); // R6
  wire count_bit = judged && locked;
  wire bit_ovf = count_bit && &bit_cnt_r;
  wire err_ovf = bit_error && &err_cnt_r;
  wire [2:0] events = {sync_change, bit_error, bit_ovf || err_ovf}; // R6
  wire [2:0] clear_bits = wr_stat ? hwdata[bert_pkg::ST_OVERFLOW_BIT:bert_pkg::ST_BIT_ERROR_BIT]
                          : 3'h0;
  // status bits 3..1 are overflow, sync change, bit error; pack to enable order
  wire [2:0] clr = {clear_bits[1], clear_bits[0], clear_bits[2]};

  // readback mux
  logic [31:0] rd_mux;
  always_comb
  begin
    case (haddr)
      bert_pkg::OFF_MUX_CTRL: rd_mux = {16'h0000, mux_ctrl_r};
      bert_pkg::OFF_CTRL0: rd_mux = {16'h0000, ctrl0_r};
      bert_pkg::OFF_PATTERN: rd_mux = pattern_r;
      bert_pkg::OFF_AWC: rd_mux = {24'h000000, awc_r};
      bert_pkg::OFF_BIT_COUNT: rd_mux = bit_latch_r;
      bert_pkg::OFF_ERR_COUNT: rd_mux = {8'h00, err_latch_r};
      bert_pkg::OFF_STATUS: rd_mux = {28'h0000000, sticky_r[0], sticky_r[2], sticky_r[1], locked};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign tx_data_out = tx_out_r;
  assign irq = |(sticky_r & irq_en); // R7

  pattern_engine u_tx_gen (
    .clk(hclk),
    .rst_n(hresetn),
    .step(tx_step),
    .check(1'b0),
    .load(tx_load_r),
    .mode(pat_sel),
    .len_code(len_code), // R18
    .pattern(pattern_r),
    .awc(awc_r),
    .rx_bit(1'b0),
    .bit_out(tx_gen),
    .aligned()
  );

  pattern_engine u_rx_chk (
    .clk(hclk),
    .rst_n(hresetn),
    .step(rx_step),
    .check(1'b1),
    .load(rx_load),
    .mode(pat_sel),
    .len_code(len_code),
    .pattern(pattern_r),
    .awc(awc_r),
    .rx_bit(rx_bit),
    .bit_out(rx_pred),
    .aligned(rx_aligned)
  );

  // bus slave: zero wait states, read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr;
      if (rd_req)
        rdata_r <= rd_mux;
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mux_ctrl_r <= bert_pkg::MUX_CTRL_RESET;
      ctrl0_r <= bert_pkg::CTRL0_RESET;
      pattern_r <= bert_pkg::PATTERN_RESET;
      awc_r <= bert_pkg::AWC_RESET;
      prev_edge_r <= 2'h0;
      tx_load_r <= 1'b0;
    end
    else
    begin
      if (wr_mux)
        mux_ctrl_r <= {12'h000, hwdata[bert_pkg::MUX_CTRL_BITS - 1:0]};
      if (wr_ctrl0)
        ctrl0_r <= hwdata[15:0] & bert_pkg::CTRL0_WMASK;
      if (wr_pat)
        pattern_r <= hwdata;
      if (wr_awc)
        awc_r <= hwdata[7:0];
      prev_edge_r <= {ctrl0_r[bert_pkg::LATCH_COUNTS_BIT], ctrl0_r[bert_pkg::FORCE_REALIGN_BIT]};
      // load a cycle late so the generator sees the new mode and pattern
      tx_load_r <= tx_load;
    end
  end

  // transmit data: generated bit when selected, line data otherwise
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_out_r <= 1'b0;
    else if (tx_bit_en)
      tx_out_r <= tx_take ? (tx_gen ^ tx_inv) : tx_data_in; // R16
  end

  // synchronizer: 32 clean bits to lock, 6 errors in 64 bits to drop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= HUNT;
      match_r <= 6'h00;
      win_r <= 6'h00;
      errs_r <= 3'h0;
    end
    else if (rx_load)
    begin
      state_r <= HUNT; // R12
      match_r <= 6'h00;
      win_r <= 6'h00;
      errs_r <= 3'h0;
    end
    else if (judged)
    begin
      case (state_r)
        HUNT:
        begin
          match_r <= mismatch ? 6'h00 : match_r + 6'h01;
          if (gain_sync)
            state_r <= LOCKED;
          win_r <= 6'h00;
          errs_r <= 3'h0;
        end
        LOCKED:
        begin
          match_r <= 6'h00;
          win_r <= (win_r == bert_pkg::LOSS_WINDOW) ? 6'h00 : win_r + 6'h01;
          if (lose_sync)
            state_r <= HUNT;
          else if (win_r == bert_pkg::LOSS_WINDOW)
            errs_r <= 3'h0;
          else if (bit_error)
            errs_r <= errs_r + 3'h1;
        end
        default: state_r <= HUNT;
      endcase
    end
  end

  // counters: latch both in one cycle and restart, a bit in that cycle is kept
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bit_cnt_r <= 32'h0000_0000;
      err_cnt_r <= 24'h000000;
      bit_latch_r <= 32'h0000_0000;
      err_latch_r <= 24'h000000;
    end
    else if (latch_rise)
    begin
      bit_latch_r <= bit_cnt_r; // R20
      err_latch_r <= err_cnt_r; // R20
      bit_cnt_r <= {31'h0, count_bit}; // R14
      err_cnt_r <= {23'h0, bit_error}; // R14
    end
    else
    begin
      if (count_bit)
        bit_cnt_r <= bit_cnt_r + 32'h1; // R5
      if (bit_error)
        err_cnt_r <= err_cnt_r + 24'h1; // R5
    end
  end

  // sticky events; a new event outranks a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sticky_r <= 3'h0;
    else
      sticky_r <= (sticky_r & ~clr) | events; // R6
  end
endmodule

// ==== pkg/bert_pkg.sv ====
/*
  Shared constants of the bit error rate tester: register map, field positions,
  reset values, pattern and mux codes, sync thresholds.
  Assumes a 32-bit AHB-Lite register bus and single-clock line strobes.
*/
package bert_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MUX_CTRL = 8'h00;
  localparam logic [7:0] OFF_CTRL0 = 8'h04;
  localparam logic [7:0] OFF_PATTERN = 8'h08;
  localparam logic [7:0] OFF_AWC = 8'h0C;
  localparam logic [7:0] OFF_BIT_COUNT = 8'h10;
  localparam logic [7:0] OFF_ERR_COUNT = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // reset values
  localparam logic [15:0] MUX_CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL0_RESET = 16'h0000;
  localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
  localparam logic [7:0] AWC_RESET = 8'h00;
  // mux control fields
  localparam int RX_SEL_LSB = 0;
  localparam int TX_SEL_LSB = 2;
  localparam int MUX_CTRL_BITS = 4;
  // control 0 fields
  localparam int FORCE_REALIGN_BIT = 0;
  localparam int LATCH_COUNTS_BIT = 1;
  localparam int PATTERN_SEL_LSB = 2;
  localparam int RX_INVERT_BIT = 5;
  localparam int TX_INVERT_BIT = 6;
  localparam int REPEAT_LEN_LSB = 8;
  localparam int OVERFLOW_IE_BIT = 13;
  localparam int BIT_ERROR_IE_BIT = 14;
  localparam int SYNC_CHANGE_IE_BIT = 15;
  localparam logic [15:0] CTRL0_WMASK = 16'hEF7F;
  // status fields
  localparam int ST_IN_SYNC_BIT = 0;
  localparam int ST_BIT_ERROR_BIT = 1;
  localparam int ST_SYNC_CHANGE_BIT = 2;
  localparam int ST_OVERFLOW_BIT = 3;
  // pattern codes
  localparam logic [2:0] PAT_PRBS7 = 3'h0;
  localparam logic [2:0] PAT_PRBS11 = 3'h1;
  localparam logic [2:0] PAT_PRBS15 = 3'h2;
  localparam logic [2:0] PAT_QRSS = 3'h3;
  localparam logic [2:0] PAT_REPEAT = 3'h4;
  localparam logic [2:0] PAT_ALT_WORD = 3'h5;
  // mux select codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ACTIVE_SLOTS = 2'h1;
  localparam logic [1:0] SEL_WHOLE_FRAME = 2'h2;
  // pattern constants and counter widths
  localparam logic [5:0] REPEAT_LEN_BASE = 6'h11;
  localparam logic [3:0] QRSS_ZERO_MAX = 4'hE;
  localparam int ALT_WORD_BITS = 16;
  localparam int BIT_COUNT_BITS = 32;
  localparam int ERR_COUNT_BITS = 24;
  // synchronizer thresholds
  localparam logic [5:0] SYNC_MATCHES = 6'h20;
  localparam logic [5:0] LOSS_WINDOW = 6'h3F;
  localparam logic [2:0] LOSS_ERRORS = 3'h6;
endpackage

// ==== src/pattern_engine.sv ====
/*
  Pattern engine: generates or predicts one bit per step for the pseudorandom,
  repetitive and alternating-word patterns. In check mode it self-synchronises
  from the received bits. Assumes step is a one-cycle bit strobe.
*/
`timescale 1ns/1ps
module pattern_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic check,
  input wire logic load,
  input wire logic [2:0] mode,
  input wire logic [3:0] len_code,
  input wire logic [31:0] pattern,
  input wire logic [7:0] awc,
  input wire logic rx_bit,
  output logic bit_out,
  output logic aligned
);
  logic [31:0] sr_r;
  logic [3:0] zrun_r;
  logic [3:0] idx_r;
  logic [7:0] rep_r;
  logic wsel_r;
  logic algn_r;

  wire [4:0] len_m1 = 5'(len_code) + 5'(bert_pkg::REPEAT_LEN_BASE - 6'h1); // R17
  wire is_prbs = (mode <= bert_pkg::PAT_QRSS);
  wire is_rep = (mode == bert_pkg::PAT_REPEAT);
  wire is_alt = (mode == bert_pkg::PAT_ALT_WORD);
  wire [15:0] word = wsel_r ? pattern[31:16] : pattern[15:0]; // R4
  wire force_one = (mode == bert_pkg::PAT_QRSS) && (zrun_r == bert_pkg::QRSS_ZERO_MAX); // R2
  wire alt_bit = word[4'hF - idx_r];
  wire rep_bit = sr_r[len_m1]; // R3
  // only the checker hunts; a generator must never cut a word short
  wire hunt_hit = check && !algn_r && ({sr_r[14:0], rx_bit} == pattern[15:0]);
  wire alt_run = !check || algn_r;
  wire word_end = (alt_run && idx_r == 4'hF) || hunt_hit;
  logic fb;

  // R1
  always_comb
  begin
    case (mode)
      bert_pkg::PAT_PRBS7: fb = sr_r[6] ^ sr_r[5];
      bert_pkg::PAT_PRBS11: fb = sr_r[10] ^ sr_r[8];
      bert_pkg::PAT_PRBS15: fb = sr_r[14] ^ sr_r[13];
      bert_pkg::PAT_QRSS: fb = sr_r[19] ^ sr_r[16];
      default: fb = 1'b0;
    endcase
  end

  wire prbs_bit = force_one | fb;
  assign bit_out = is_prbs ? prbs_bit : (is_rep ? rep_bit : alt_bit);
  assign aligned = !(check && is_alt) || algn_r;

  // forced ones are not part of the lfsr sequence, so the raw bit is shifted in
  wire shift_in = is_prbs ? ((check && !force_one) ? rx_bit : fb) :
                  (is_rep && !check) ? rep_bit : (check ? rx_bit : alt_bit);
  wire emitted = check ? rx_bit : bit_out;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_r <= 32'hFFFF_FFFF;
      zrun_r <= 4'h0;
      idx_r <= 4'h0;
      rep_r <= 8'h00;
      wsel_r <= 1'b0;
      algn_r <= 1'b0;
    end
    else if (load)
    begin
      sr_r <= (is_rep && !check) ? pattern : 32'hFFFF_FFFF;
      zrun_r <= 4'h0;
      idx_r <= 4'h0;
      rep_r <= 8'h00;
      wsel_r <= 1'b0;
      algn_r <= 1'b0;
    end
    else if (step)
    begin
      sr_r <= {sr_r[30:0], shift_in};
      zrun_r <= (emitted || zrun_r == bert_pkg::QRSS_ZERO_MAX) ? 4'h0 : zrun_r + 4'h1;
      if (is_alt && hunt_hit)
        algn_r <= check;
      if (is_alt && (alt_run || hunt_hit))
        idx_r <= word_end ? 4'h0 : idx_r + 4'h1;
      if (is_alt && word_end)
      begin
        // run length is awc plus one words
        rep_r <= (rep_r == awc) ? 8'h00 : rep_r + 8'h01;
        wsel_r <= (rep_r == awc) ? !wsel_r : wsel_r;
      end
    end
  end
endmodule

// ==== testbench/bert_props.sv ====
/*
  Checker for bert: bus answer, read-back, transmit pass-through and irq masking.
  Assumes it is bound to bert and mirrors the control registers by snooping bus writes.
*/
`timescale 1ns/1ps
module bert_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic tx_bit_en,
  input wire logic tx_active_slot,
  input wire logic tx_data_in,
  input wire logic tx_data_out,
  input wire logic irq
);
  logic ap_wr;
  logic [7:0] ap_a;
  logic [3:0] mux_r;
  logic [15:0] c0_r;
  wire take = hsel && hready && htrans[1] && hsize == 3'h2;
  wire [1:0] tsel = mux_r[3:2];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ap_wr <= 1'b0;
      ap_a <= 8'h00;
    end
    else
    begin
      ap_wr <= take && hwrite;
      ap_a <= haddr;
    end
  // write lands at the end of its data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      mux_r <= 4'h0;
      c0_r <= 16'h0000;
    end
    else if (ap_wr && ap_a == bert_pkg::OFF_MUX_CTRL)
      mux_r <= hwdata[3:0];
    else if (ap_wr && ap_a == bert_pkg::OFF_CTRL0)
      c0_r <= hwdata[15:0] & bert_pkg::CTRL0_WMASK;
  logic reload_r;
  logic pend_r;
  logic [4:0] zeros_r;
  wire reload = ap_wr && ap_a <= bert_pkg::OFF_AWC;
  wire qrss_on = c0_r[bert_pkg::PATTERN_SEL_LSB +: 3] == bert_pkg::PAT_QRSS
                 && !c0_r[bert_pkg::TX_INVERT_BIT] && tsel == bert_pkg::SEL_WHOLE_FRAME;
  // bits still in flight from before a reload do not belong to the new run
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      reload_r <= 1'b0;
      pend_r <= 1'b0;
      zeros_r <= 5'h00;
    end
    else
    begin
      reload_r <= reload;
      if (reload || reload_r)
        pend_r <= 1'b1;
      else if (tx_bit_en)
        pend_r <= 1'b0;
      if (reload || reload_r || pend_r || !qrss_on)
        zeros_r <= 5'h00;
      else if (tx_bit_en)
        zeros_r <= tx_data_out ? 5'h00 : zeros_r + 5'h01;
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus stall or error response");
  // a read right behind a write still sees the old value
  property p_rd_mux; take && !hwrite && haddr == bert_pkg::OFF_MUX_CTRL
    |=> hrdata == {28'h0, $past(mux_r)}; endproperty
  a_rd_mux: assert property (p_rd_mux) else $error("mux read-back wrong");
  property p_rd_c0; take && !hwrite && haddr == bert_pkg::OFF_CTRL0
    |=> hrdata == {16'h0, $past(c0_r)}; endproperty
  a_rd_c0: assert property (p_rd_c0) else $error("control read-back wrong");
  property p_tx_off; tx_bit_en && tsel == bert_pkg::SEL_OFF
    |=> tx_data_out == $past(tx_data_in); endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx off did not pass data");
  property p_tx_ill; tx_bit_en && tsel == 2'h3 |=> tx_data_out == $past(tx_data_in); endproperty
  a_tx_ill: assert property (p_tx_ill) else $error("illegal tx select replaced data");
  property p_tx_slot; tx_bit_en && tsel == bert_pkg::SEL_ACTIVE_SLOTS && !tx_active_slot
    |=> tx_data_out == $past(tx_data_in); endproperty
  a_tx_slot: assert property (p_tx_slot) else $error("overhead bit replaced");
  property p_hold; !tx_bit_en |=> $stable(tx_data_out); endproperty
  a_hold: assert property (p_hold) else $error("tx output moved without strobe");
  property p_irq; c0_r[15:13] == 3'h0 |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("irq with all sources masked");
  property p_qrss_run; zeros_r <= 5'h0E; endproperty
  a_qrss_run: assert property (p_qrss_run) else $error("qrss zero run above fourteen");
endmodule

bind bert bert_props u_props (.*);

// ==== testbench/line_partner.sv ====
/*
  Formatter and framer data paths looped back through the tester.
  Assumes the block's clock; bits strobed every cycle, or every other when slow.
*/
`timescale 1ns/1ps
module line_partner #(
  parameter int FRAME_BITS = 789,
  parameter int OVERHEAD_BITS = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic flip,
  input wire logic tx_data_out,
  output logic tx_bit_en,
  output logic tx_active_slot,
  output logic tx_data_in,
  output logic rx_bit_en,
  output logic rx_active_slot,
  output logic rx_data_in
);
  logic [9:0] pos_r;
  logic en_d;
  logic act_d;
  logic flip_r;
  wire f = flip | flip_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {tx_bit_en, tx_active_slot, tx_data_in, en_d, act_d, flip_r} <= 6'h00;
      {rx_bit_en, rx_active_slot, rx_data_in} <= 3'h0;
      pos_r <= 10'h000;
    end
    else
    begin
      tx_bit_en <= slow ? !tx_bit_en : 1'b1;
      if (tx_bit_en)
        pos_r <= (int'(pos_r) == FRAME_BITS - 1) ? 10'h000 : pos_r + 10'h001;
      tx_active_slot <= int'(pos_r) >= OVERHEAD_BITS;
      tx_data_in <= pos_r[0] ^ pos_r[3];
      en_d <= tx_bit_en;
      act_d <= tx_active_slot;
      rx_bit_en <= en_d;
      rx_active_slot <= act_d;
      // idle line toggles so a stale bit is never mistaken for data
      rx_data_in <= en_d ? tx_data_out ^ f : !rx_data_in;
      flip_r <= !en_d && f;
    end
endmodule

// ==== testbench/bert_test.sv ====
/*
  Bench for bert: registers, pass-through, pattern lock, inversion, latch and irq.
  Assumes line_partner in loopback and hready fed from hreadyout.
*/
`timescale 1ns/1ps
module bert_test;
  typedef struct packed {logic [3:0] mux; logic [15:0] c0; logic [31:0] pat;
    logic [5:0] per; logic lock;} case_t;
  logic hclk, hresetn, hsel, hwrite, slow, flip, got;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, q;
  wire hready, hreadyout, hresp, irq;
  wire [31:0] hrdata;
  wire tx_bit_en, tx_active_slot, tx_data_in, tx_data_out;
  wire rx_bit_en, rx_active_slot, rx_data_in;
  int n_errors;
  int cmp_count;
  case_t tab [13] = '{
    '{4'hA, 16'h0000, 32'h0, 6'h0, 1'b1},
    '{4'h5, 16'h0004, 32'h0, 6'h0, 1'b1},
    '{4'hA, 16'h0008, 32'h0, 6'h0, 1'b1},
    '{4'hA, 16'h000C, 32'h0, 6'h0, 1'b1},
    '{4'hA, 16'h0010, 32'h0001_2345, 6'h11, 1'b1},
    '{4'hA, 16'h0F10, 32'h8765_4321, 6'h20, 1'b1},
    '{4'hA, 16'h0110, 32'h0002_CB2C, 6'h06, 1'b1},
    '{4'hA, 16'h0014, 32'h0F0F_00FF, 6'h20, 1'b1},
    '{4'hA, 16'h0054, 32'h0F0F_00FF, 6'h20, 1'b0},
    '{4'hA, 16'h0074, 32'h0F0F_00FF, 6'h20, 1'b1},
    '{4'hA, 16'h0018, 32'h0, 6'h0, 1'b0},
    '{4'hA, 16'h0F00, 32'h0, 6'h0, 1'b1},
    '{4'h8, 16'h0000, 32'h0, 6'h0, 1'b0}};
  assign hready = hreadyout;
  bert DUT (.*);
  line_partner u_line (.clk(hclk), .rst_n(hresetn), .*);
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
    begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic poll_lock;
    got = 1'b0;
    for (int i = 0; i < 80 && !got; i++)
    begin
      bus(1'b0, bert_pkg::OFF_STATUS, 32'h0);
      got = q[bert_pkg::ST_IN_SYNC_BIT];
    end
  endtask
  task automatic pass_check;
    logic prev;
    repeat (4)
    begin
      @(posedge hclk);
      prev = tx_data_in;
      @(posedge hclk);
      check("pass", {31'h0, tx_data_out}, {31'h0, prev});
    end
  endtask
  // a period mismatch anywhere in the window flags the pattern length
  task automatic per_check(input int per);
    logic [63:0] s;
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge hclk);
      s[i] = tx_data_out;
    end
    for (int i = 0; i + per < 64; i++)
      bad |= s[i] !== s[i + per];
    check("period", {31'h0, bad}, 32'h0);
  endtask
  initial
  begin
    {hresetn, hsel, hwrite, slow, flip} = 5'h00;
    {haddr, htrans, hwdata, n_errors, cmp_count} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, 8'(4 * i), 32'h0);
      check("reset value", q, 32'h0);
    end
    bus(1'b1, bert_pkg::OFF_MUX_CTRL, 32'hFFFF_FFFF);
    bus(1'b0, bert_pkg::OFF_MUX_CTRL, 32'h0);
    check("mux", q, 32'h0000_000F);
    pass_check();
    bus(1'b1, bert_pkg::OFF_CTRL0, 32'hFFFF_FFFF);
    bus(1'b0, bert_pkg::OFF_CTRL0, 32'h0);
    check("ctrl0", q, 32'h0000_EF7F);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h1C, 32'h0);
    check("unmapped", q, 32'h0);
    bus(1'b1, bert_pkg::OFF_MUX_CTRL, 32'h0);
    pass_check();
    bus(1'b1, bert_pkg::OFF_AWC, 32'h0);
    $display("test registers done");
    foreach (tab[i])
    begin
      bus(1'b1, bert_pkg::OFF_MUX_CTRL, {28'h0, tab[i].mux});
      bus(1'b1, bert_pkg::OFF_PATTERN, tab[i].pat);
      bus(1'b1, bert_pkg::OFF_CTRL0, {16'h0, tab[i].c0});
      poll_lock();
      check("lock", {31'h0, got}, {31'h0, tab[i].lock});
      if (tab[i].per != 6'h0)
        per_check(int'(tab[i].per));
    end
    $display("test patterns done");
    slow <= 1'b1;
    bus(1'b1, bert_pkg::OFF_MUX_CTRL, 32'hA);
    bus(1'b1, bert_pkg::OFF_PATTERN, 32'h0F0F_00FF);
    bus(1'b1, bert_pkg::OFF_CTRL0, 32'h4016);
    poll_lock();
    bus(1'b1, bert_pkg::OFF_STATUS, 32'hF);
    @(posedge hclk);
    check("irq idle", {31'h0, irq}, 32'h0);
    flip <= 1'b1;
    @(posedge hclk);
    flip <= 1'b0;
    repeat (3) bus(1'b0, bert_pkg::OFF_STATUS, 32'h0);
    check("error flag", {31'h0, q[bert_pkg::ST_BIT_ERROR_BIT]}, 32'h1);
    check("irq on", {31'h0, irq}, 32'h1);
    bus(1'b1, bert_pkg::OFF_CTRL0, 32'h0014);
    @(posedge hclk);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1'b1, bert_pkg::OFF_CTRL0, 32'h4016);
    // latch acts the cycle after the write lands
    @(posedge hclk);
    bus(1'b0, bert_pkg::OFF_ERR_COUNT, 32'h0);
    check("errors", q, 32'h1);
    bus(1'b0, bert_pkg::OFF_BIT_COUNT, 32'h0);
    check("bits", {31'h0, q != 32'h0}, 32'h1);
    bus(1'b1, bert_pkg::OFF_CTRL0, 32'h4014);
    bus(1'b1, bert_pkg::OFF_CTRL0, 32'h4015);
    poll_lock();
    check("realign", {31'h0, got}, 32'h1);
    $display("test counters done");
    complete_run();
  end
endmodule
